// ===== rtl/gegi_core.sv
// Global event gate, pending event holding and guest event injection.
// Assumes one 100 MHz clock, a classic Wishbone master and core
// event strobes on the same clock; the two pins pass a synchroniser.
//
// Contract
// - Gate set instruction sets, clear clears gate
// - Gate low drops breakpoint debug, I/O SMI
// - Gate low holds INIT, NMI, SMI, interrupts pending
// - Trace, reset, debug request, A20 ignore gate
// - Machine check gate low: hold or shutdown
// - Redirected INIT becomes security exception only gate high
// - Config bits alone govern debug request, A20
// - Hypervisor call unintercepted raises invalid opcode
// - Valid descriptor injects at entry before guest code
// - Injection recorded, intercepts only for secondary faults
// - Injected NMI leaves NMI blocking untouched
// - Impossible injected event exits with invalid state
// - Type 3 vector 3/4 acts as trap, DPL checked
// - Vector bits 7-0, type bits 10-8, NMI ignores vector
// - Inject only when descriptor valid bit 31 set
// - Types: 0 interrupt, 2 NMI, 3 exception, 4 soft
// - Reserved type or non-exception vector fails entry
// - Capability bit reports next instruction pointer support
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module gegi_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] wbAdrI,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  input wire logic wbWeI,
  input wire logic [3:0] wbSelI,
  input wire logic wbCycI,
  input wire logic wbStbI,
  output logic wbAckO,
  input wire logic instrBoundary,
  input wire logic gateSetInstr,
  input wire logic gateClearInstr,
  input wire logic hypCallInstr,
  input wire logic hypCallIntercepted,
  input wire logic bpDebugEvent,
  input wire logic ioSmiEvent,
  input wire logic traceTrap,
  input wire logic invisibleEvent,
  input wire logic initEvent,
  input wire logic nmiEvent,
  input wire logic extSmiEvent,
  input wire logic intrEvent,
  input wire logic virtualMaskableInterrupt,
  input wire logic machineCheck,
  input wire logic nmiReturn,
  input wire logic debugRequestInput,
  input wire logic a20MaskPin,
  input wire logic guestEntry,
  input wire logic guestLongMode,
  input wire logic secondaryException,
  input wire logic secondaryIntercepted,
  output logic deliverBpDebug,
  output logic deliverIoSmi,
  output logic deliverTrace,
  output logic deliverInvisible,
  output logic deliverMachineCheck,
  output logic deliverExtSmi,
  output logic deliverInit,
  output logic deliverSecurityException,
  output logic deliverNmi,
  output logic deliverIntr,
  output logic deliverVintr,
  output logic shutdown,
  output logic deliverDebugReq,
  output logic a20MaskActive,
  output logic invalidOpcode,
  output logic injectValid,
  output logic [2:0] injectType,
  output logic [7:0] injectVector,
  output logic injectErrValid,
  output logic [31:0] injectErrCode,
  output logic injectTrapDplCheck,
  output logic entryInvalid,
  output logic secondaryExit
);
  ////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [31:0] gegi_merge(input logic [31:0] old,
      input logic [31:0] din, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = din[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [5:0] gegi_first(input logic [5:0] x);
    return x & (6'((~x) + 6'h01));
  endfunction
  function automatic logic gegi_exc_vec(input logic [7:0] v);
    return (v < gegi_pkg::VEC_EXC_LIMIT) && (v != gegi_pkg::VEC_NMI);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic gate_reg;
  logic [3:0] ctrl_reg;
  logic [31:0] descLo_reg;
  logic [31:0] descHi_reg;
  logic [31:0] exitLo_reg;
  logic [31:0] exitHi_reg;
  logic [5:0] pend_reg;
  logic [5:0] pend_next;
  logic [5:0] newPend;
  logic [5:0] allowed;
  logic [5:0] take;
  logic nmiBlocked_reg;
  logic dbgMeta_reg;
  logic dbgSync_reg;
  logic a20Meta_reg;
  logic a20Sync_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic busReq;
  logic [2:0] dType;
  logic [7:0] dVec;
  logic typeOk;
  logic eventOk;
  logic descValid;

  assign busReq = wbCycI && wbStbI && !ack_reg;
  assign wbAckO = ack_reg;
  assign wbDatO = rdat_reg;

  ////////////////////////////////////////////////////////////////////////
  // Register bus slave
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= busReq;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdat_reg <= 32'h0;
    end else if (busReq && !wbWeI) begin
      unique case (wbAdrI)
        gegi_pkg::OFS_CTRL: rdat_reg <= {28'h0, ctrl_reg};
        gegi_pkg::OFS_DESC_LO: rdat_reg <= descLo_reg;
        gegi_pkg::OFS_DESC_HI: rdat_reg <= descHi_reg;
        gegi_pkg::OFS_STATUS: begin
          rdat_reg <= {18'h0, pend_reg, 6'h0, nmiBlocked_reg, gate_reg};
        end
        gegi_pkg::OFS_EXIT_LO: rdat_reg <= exitLo_reg;
        gegi_pkg::OFS_EXIT_HI: rdat_reg <= exitHi_reg;
        gegi_pkg::OFS_CAP:
          rdat_reg <= {31'h0, gegi_pkg::NEXT_IP_SUPPORT};
        default: rdat_reg <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= gegi_pkg::CTRL_RST;
      descLo_reg <= gegi_pkg::DESC_RST;
      descHi_reg <= gegi_pkg::DESC_RST;
    end else if (busReq && wbWeI) begin
      if (wbAdrI == gegi_pkg::OFS_CTRL && wbSelI[0]) begin
        ctrl_reg <= wbDatI[3:0];
      end
      if (wbAdrI == gegi_pkg::OFS_DESC_LO) begin
        descLo_reg <= gegi_merge(descLo_reg, wbDatI, wbSelI);
      end
      if (wbAdrI == gegi_pkg::OFS_DESC_HI) begin
        descHi_reg <= gegi_merge(descHi_reg, wbDatI, wbSelI);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Global event gate
  always_ff @(posedge clock) begin
    if (rst) begin
      gate_reg <= gegi_pkg::GATE_RST;
    end else if (gateSetInstr) begin
      gate_reg <= 1'b1;
    end else if (gateClearInstr) begin
      gate_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, gate independent events and events the closed gate drops
  always_ff @(posedge clock) begin
    if (rst) begin
      dbgMeta_reg <= 1'b0;
      dbgSync_reg <= 1'b0;
      a20Meta_reg <= 1'b0;
      a20Sync_reg <= 1'b0;
    end else begin
      dbgMeta_reg <= debugRequestInput;
      dbgSync_reg <= dbgMeta_reg;
      a20Meta_reg <= a20MaskPin;
      a20Sync_reg <= a20Meta_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      deliverTrace <= 1'b0;
      deliverInvisible <= 1'b0;
      deliverDebugReq <= 1'b0;
      a20MaskActive <= 1'b0;
      deliverBpDebug <= 1'b0;
      deliverIoSmi <= 1'b0;
      invalidOpcode <= 1'b0;
    end else begin
      deliverTrace <= traceTrap;
      deliverInvisible <= invisibleEvent;
      deliverDebugReq <= dbgSync_reg && !ctrl_reg[gegi_pkg::CTRL_DPD];
      a20MaskActive <= a20Sync_reg && !ctrl_reg[gegi_pkg::CTRL_A20D];
      deliverBpDebug <= bpDebugEvent && gate_reg;
      deliverIoSmi <= ioSmiEvent && gate_reg;
      invalidOpcode <= hypCallInstr && !hypCallIntercepted;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Held events and their delivery
  always_comb begin
    newPend = '0;
    newPend[gegi_pkg::PEND_MC] = machineCheck &&
        (gate_reg || ctrl_reg[gegi_pkg::CTRL_MC_HOLD]);
    newPend[gegi_pkg::PEND_XSMI] = extSmiEvent;
    newPend[gegi_pkg::PEND_INIT] = initEvent;
    newPend[gegi_pkg::PEND_NMI] = nmiEvent;
    newPend[gegi_pkg::PEND_INTR] = intrEvent;
    newPend[gegi_pkg::PEND_VIRTUAL_MASKABLE_INTERRUPT] = virtualMaskableInterrupt;
    allowed = pend_reg;
    allowed[gegi_pkg::PEND_NMI] = pend_reg[gegi_pkg::PEND_NMI] &&
        !nmiBlocked_reg;
    take = (gate_reg && instrBoundary) ? gegi_first(allowed) : 6'h00;
    pend_next = (pend_reg & ~take) | newPend;
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      deliverMachineCheck <= 1'b0;
      deliverExtSmi <= 1'b0;
      deliverInit <= 1'b0;
      deliverSecurityException <= 1'b0;
      deliverNmi <= 1'b0;
      deliverIntr <= 1'b0;
      deliverVintr <= 1'b0;
      shutdown <= 1'b0;
    end else begin
      deliverMachineCheck <= take[gegi_pkg::PEND_MC];
      deliverExtSmi <= take[gegi_pkg::PEND_XSMI];
      deliverInit <= take[gegi_pkg::PEND_INIT] &&
          !ctrl_reg[gegi_pkg::CTRL_INIT_REDIR];
      deliverSecurityException <= take[gegi_pkg::PEND_INIT] &&
          ctrl_reg[gegi_pkg::CTRL_INIT_REDIR];
      deliverNmi <= take[gegi_pkg::PEND_NMI];
      deliverIntr <= take[gegi_pkg::PEND_INTR];
      deliverVintr <= take[gegi_pkg::PEND_VIRTUAL_MASKABLE_INTERRUPT];
      shutdown <= machineCheck && !gate_reg &&
          !ctrl_reg[gegi_pkg::CTRL_MC_HOLD];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      nmiBlocked_reg <= 1'b0;
    end else if (take[gegi_pkg::PEND_NMI]) begin
      nmiBlocked_reg <= 1'b1;
    end else if (nmiReturn) begin
      nmiBlocked_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Injection descriptor decode
  assign dVec = descLo_reg[gegi_pkg::DESC_VEC_LSB +: 8];
  assign dType = descLo_reg[gegi_pkg::DESC_TYPE_LSB +: 3];
  assign descValid = descLo_reg[gegi_pkg::DESC_VALID];

  always_comb begin
    typeOk = 1'b0;
    eventOk = 1'b1;
    unique case (dType)
      gegi_pkg::TYPE_INTR: typeOk = 1'b1;
      gegi_pkg::TYPE_NMI: typeOk = 1'b1;
      gegi_pkg::TYPE_EXC: begin
        typeOk = gegi_exc_vec(dVec);
        eventOk = !(guestLongMode && dVec == gegi_pkg::VEC_BR);
      end
      gegi_pkg::TYPE_SWINT: typeOk = 1'b1;
      default: typeOk = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      injectValid <= 1'b0;
      entryInvalid <= 1'b0;
      injectType <= 3'h0;
      injectVector <= 8'h00;
      injectErrValid <= 1'b0;
      injectErrCode <= 32'h0;
      injectTrapDplCheck <= 1'b0;
    end else begin
      injectValid <= guestEntry && descValid && typeOk && eventOk;
      entryInvalid <= guestEntry && descValid && !(typeOk && eventOk);
      if (guestEntry && descValid) begin
        injectType <= dType;
        injectVector <= (dType == gegi_pkg::TYPE_NMI) ?
            gegi_pkg::VEC_NMI : dVec;
        injectErrValid <= descLo_reg[gegi_pkg::DESC_EV];
        injectErrCode <= descLo_reg[gegi_pkg::DESC_EV] ?
            descHi_reg : 32'h0;
        injectTrapDplCheck <= (dType == gegi_pkg::TYPE_EXC) &&
            (dVec == gegi_pkg::VEC_BP || dVec == gegi_pkg::VEC_OF);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      exitLo_reg <= 32'h0;
      exitHi_reg <= 32'h0;
    end else if (guestEntry && descValid && typeOk && eventOk) begin
      exitLo_reg <= descLo_reg;
      exitHi_reg <= descHi_reg;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      secondaryExit <= 1'b0;
    end else begin
      secondaryExit <= secondaryException && secondaryIntercepted;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  gate_set_a: assert property (@(posedge clock) disable iff (rst)
      gateSetInstr |=> gate_reg) else $error("gate not set");
  gate_clr_a: assert property (@(posedge clock) disable iff (rst)
      gateClearInstr && !gateSetInstr |=> !gate_reg)
      else $error("gate not cleared");
  drop_bp_a: assert property (@(posedge clock) disable iff (rst)
      bpDebugEvent && !gate_reg |=> !deliverBpDebug)
      else $error("breakpoint event passed closed gate");
  hold_nmi_a: assert property (@(posedge clock) disable iff (rst)
      !gate_reg && nmiEvent |=> pend_reg[gegi_pkg::PEND_NMI] &&
      !deliverNmi) else $error("nmi not held");
  no_take_a: assert property (@(posedge clock) disable iff (rst)
      !gate_reg |=> !(deliverIntr || deliverVintr || deliverExtSmi))
      else $error("event taken with gate closed");
  trace_pass_a: assert property (@(posedge clock) disable iff (rst)
      traceTrap |=> deliverTrace) else $error("trace trap lost");
  mc_shut_a: assert property (@(posedge clock) disable iff (rst)
      machineCheck && !gate_reg && !ctrl_reg[gegi_pkg::CTRL_MC_HOLD]
      |=> shutdown) else $error("no shutdown");
  sx_gate_a: assert property (@(posedge clock) disable iff (rst)
      deliverSecurityException |-> $past(gate_reg))
      else $error("security exception with gate closed");
  dbg_dis_a: assert property (@(posedge clock) disable iff (rst)
      ctrl_reg[gegi_pkg::CTRL_DPD] |=> !deliverDebugReq)
      else $error("debug request with port disabled");
  hcall_ud_a: assert property (@(posedge clock) disable iff (rst)
      hypCallInstr && !hypCallIntercepted |=> invalidOpcode)
      else $error("missing invalid opcode");
  inj_fire_a: assert property (@(posedge clock) disable iff (rst)
      guestEntry && descValid && typeOk && eventOk |=> injectValid &&
      !entryInvalid) else $error("injection missing");
  inj_nmi_a: assert property (@(posedge clock) disable iff (rst)
      injectValid && injectType == gegi_pkg::TYPE_NMI &&
      !take[gegi_pkg::PEND_NMI] |=> !$rose(nmiBlocked_reg))
      else $error("injected nmi changed blocking");
  bad_type_a: assert property (@(posedge clock) disable iff (rst)
      guestEntry && descValid && dType > gegi_pkg::TYPE_SWINT
      |=> entryInvalid && !injectValid) else $error("reserved type taken");
  no_valid_a: assert property (@(posedge clock) disable iff (rst)
      guestEntry && !descValid |=> !injectValid && !entryInvalid)
      else $error("injection without valid bit");
endmodule

// ===== rtl/gegi_pkg.sv
// Constants for the guest event gating and injection block.
// Shared by the core module and any bench that drives its registers.
package gegi_pkg;
  // Register byte offsets on the register bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DESC_LO = 8'h04;
  localparam logic [7:0] OFS_DESC_HI = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_EXIT_LO = 8'h10;
  localparam logic [7:0] OFS_EXIT_HI = 8'h14;
  localparam logic [7:0] OFS_CAP = 8'h18;
  // Control register fields
  localparam int CTRL_DPD = 0;
  localparam int CTRL_A20D = 1;
  localparam int CTRL_INIT_REDIR = 2;
  localparam int CTRL_MC_HOLD = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // Descriptor fields
  localparam int DESC_VEC_LSB = 0;
  localparam int DESC_TYPE_LSB = 8;
  localparam int DESC_EV = 11;
  localparam int DESC_VALID = 31;
  localparam logic [31:0] DESC_RST = 32'h0;
  // Event type codes
  localparam logic [2:0] TYPE_INTR = 3'h0;
  localparam logic [2:0] TYPE_NMI = 3'h2;
  localparam logic [2:0] TYPE_EXC = 3'h3;
  localparam logic [2:0] TYPE_SWINT = 3'h4;
  // Vectors with special meaning
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_BP = 8'h03;
  localparam logic [7:0] VEC_OF = 8'h04;
  localparam logic [7:0] VEC_BR = 8'h05;
  localparam logic [7:0] VEC_EXC_LIMIT = 8'h20;
  // Pending event slots, lowest index has highest priority
  localparam int PEND_W = 6;
  localparam int PEND_MC = 0;
  localparam int PEND_XSMI = 1;
  localparam int PEND_INIT = 2;
  localparam int PEND_NMI = 3;
  localparam int PEND_INTR = 4;
  localparam int PEND_VIRTUAL_MASKABLE_INTERRUPT = 5;
  // Status register fields
  localparam int STAT_GATE = 0;
  localparam int STAT_NMIBLK = 1;
  localparam int STAT_PEND_LSB = 8;
  // Gate reset value and capability bit
  localparam logic GATE_RST = 1'b1;
  localparam logic NEXT_IP_SUPPORT = 1'b1;
endpackage

// ===== tb/test_gegi_core.sv
// Self-checking bench for the guest event gating and injection core.
// Assumes registered one-cycle pulses and a one-cycle Wishbone ack.
`timescale 1ns/1ps
module test_gegi_core;
  `define CHK(a, b, m) begin \
    compares++; \
    if ((a) !== (b)) begin \
      errTotal++; \
      $display("mismatch %0t %s", $time, m); \
    end \
  end
  localparam logic [16:0] P_BND = 17'h10000, P_SET = 17'h08000,
    P_CLR = 17'h04000, P_HYP = 17'h02000, P_BP = 17'h01000,
    P_IOS = 17'h00800, P_TRC = 17'h00400, P_INV = 17'h00200,
    P_INIT = 17'h00100, P_NMI = 17'h00080, P_XSMI = 17'h00040,
    P_INTR = 17'h00020, P_VINT = 17'h00010, P_MC = 17'h00008,
    P_NRET = 17'h00004, P_ENT = 17'h00002, P_SEC = 17'h00001;
  int errTotal = 0;
  int compares = 0;
  logic clock, rst, wbWeI, wbCycI, wbStbI, wbAckO;
  logic [7:0] wbAdrI;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [3:0] wbSelI;
  logic hypCallIntercepted, debugRequestInput, a20MaskPin;
  logic guestLongMode, secondaryIntercepted;
  logic [16:0] pv;
  wire instrBoundary, gateSetInstr, gateClearInstr, hypCallInstr;
  wire bpDebugEvent, ioSmiEvent, traceTrap, invisibleEvent, initEvent;
  wire nmiEvent, extSmiEvent, intrEvent, virtualMaskableInterrupt;
  wire machineCheck, nmiReturn, guestEntry, secondaryException;
  logic deliverBpDebug, deliverIoSmi, deliverTrace, deliverInvisible;
  logic deliverMachineCheck, deliverExtSmi, deliverInit, deliverNmi;
  logic deliverSecurityException, deliverIntr, deliverVintr, shutdown;
  logic deliverDebugReq, a20MaskActive, invalidOpcode, injectValid;
  logic injectErrValid, injectTrapDplCheck, entryInvalid, secondaryExit;
  logic [2:0] injectType;
  logic [7:0] injectVector;
  logic [31:0] injectErrCode;
  assign {instrBoundary, gateSetInstr, gateClearInstr, hypCallInstr,
    bpDebugEvent, ioSmiEvent, traceTrap, invisibleEvent, initEvent,
    nmiEvent, extSmiEvent, intrEvent, virtualMaskableInterrupt,
    machineCheck, nmiReturn, guestEntry, secondaryException} = pv;
  typedef struct packed {
    logic [31:0] lo;
    logic lm;
    logic ok;
    logic bad;
    logic [7:0] vec;
    logic dpl;
  } gegi_row_s;
  gegi_row_s rows [12] = '{
    '{32'h80000020, 1'h0, 1'h1, 1'h0, 8'h20, 1'h0},
    '{32'h80000205, 1'h0, 1'h1, 1'h0, 8'h02, 1'h0},
    '{32'h80000303, 1'h0, 1'h1, 1'h0, 8'h03, 1'h1},
    '{32'h80000304, 1'h0, 1'h1, 1'h0, 8'h04, 1'h1},
    '{32'h80000480, 1'h0, 1'h1, 1'h0, 8'h80, 1'h0},
    '{32'h80000b0e, 1'h1, 1'h1, 1'h0, 8'h0e, 1'h0},
    '{32'h80000305, 1'h1, 1'h0, 1'h1, 8'h05, 1'h0},
    '{32'h80000100, 1'h0, 1'h0, 1'h1, 8'h00, 1'h0},
    '{32'h80000302, 1'h0, 1'h0, 1'h1, 8'h02, 1'h0},
    '{32'h80000320, 1'h0, 1'h0, 1'h1, 8'h20, 1'h0},
    '{32'h80000700, 1'h0, 1'h0, 1'h1, 8'h00, 1'h0},
    '{32'h00000320, 1'h0, 1'h0, 1'h0, 8'h20, 1'h0}};

  gegi_core gegi_core_inst (.clock, .rst, .wbAdrI, .wbDatI, .wbDatO,
    .wbWeI, .wbSelI, .wbCycI, .wbStbI, .wbAckO, .instrBoundary,
    .gateSetInstr, .gateClearInstr, .hypCallInstr, .hypCallIntercepted,
    .bpDebugEvent, .ioSmiEvent, .traceTrap, .invisibleEvent, .initEvent,
    .nmiEvent, .extSmiEvent, .intrEvent, .virtualMaskableInterrupt,
    .machineCheck, .nmiReturn, .debugRequestInput, .a20MaskPin,
    .guestEntry, .guestLongMode, .secondaryException,
    .secondaryIntercepted, .deliverBpDebug, .deliverIoSmi, .deliverTrace,
    .deliverInvisible, .deliverMachineCheck, .deliverExtSmi, .deliverInit,
    .deliverSecurityException, .deliverNmi, .deliverIntr, .deliverVintr,
    .shutdown, .deliverDebugReq, .a20MaskActive, .invalidOpcode,
    .injectValid, .injectType, .injectVector, .injectErrValid,
    .injectErrCode, .injectTrapDplCheck, .entryInvalid, .secondaryExit);

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (errTotal == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic pulse(input logic [16:0] m);
    @(posedge clock);
    pv <= m;
    @(posedge clock);
    pv <= '0;
    #1;
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clock);
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    wbWeI <= we;
    wbAdrI <= a;
    wbDatI <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wbAckO !== 1'b1);
    `CHK(n, 2, "ack latency")
    rd = wbDatO;
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    wbWeI <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string m);
    wb(1'b0, a, 32'h0);
    `CHK(rd, e, m)
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (5000) @(posedge clock);
    errTotal++;
    results();
  end

  initial begin
    rst = 1'b1;
    pv = '0;
    wbCycI = 1'b0;
    wbStbI = 1'b0;
    wbWeI = 1'b0;
    wbAdrI = 8'h00;
    wbDatI = 32'h0;
    wbSelI = 4'hf;
    hypCallIntercepted = 1'b0;
    debugRequestInput = 1'b0;
    a20MaskPin = 1'b0;
    guestLongMode = 1'b0;
    secondaryIntercepted = 1'b0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    wb(1'b1, gegi_pkg::OFS_DESC_HI, 32'h00001234);
    foreach (rows[i]) begin
      wb(1'b1, gegi_pkg::OFS_DESC_LO, rows[i].lo);
      @(posedge clock);
      guestLongMode <= rows[i].lm;
      pulse(P_ENT);
      `CHK(injectValid, rows[i].ok, "inject")
      `CHK(entryInvalid, rows[i].bad, "invalid")
      if (rows[i].ok) begin
        `CHK(injectType, rows[i].lo[10:8], "type")
        `CHK(injectVector, rows[i].vec, "vector")
        `CHK(injectTrapDplCheck, rows[i].dpl, "dpl")
        `CHK(injectErrValid, rows[i].lo[11], "ev")
        if (rows[i].lo[11]) begin
          `CHK(injectErrCode, 32'h00001234, "code")
        end
      end
    end
    // Hand-written cases
    rchk(gegi_pkg::OFS_EXIT_LO, 32'h80000b0e, "exit lo");
    rchk(gegi_pkg::OFS_EXIT_HI, 32'h00001234, "exit hi");
    rchk(gegi_pkg::OFS_STATUS, 32'h00000001, "status");
    wb(1'b1, gegi_pkg::OFS_CAP, 32'h0);
    rchk(gegi_pkg::OFS_CAP, 32'h00000001, "cap");
    rchk(8'h40, 32'h0, "unmapped");
    pulse(P_CLR);
    rchk(gegi_pkg::OFS_STATUS, 32'h0, "gate clear");
    pulse(P_BP | P_IOS | P_TRC | P_INV | P_NMI | P_INTR);
    `CHK(deliverBpDebug, 1'b0, "bp dropped")
    `CHK(deliverIoSmi, 1'b0, "iosmi dropped")
    `CHK(deliverTrace, 1'b1, "trace")
    `CHK(deliverInvisible, 1'b1, "invisible")
    pulse(P_BND);
    `CHK(deliverNmi, 1'b0, "nmi held")
    rchk(gegi_pkg::OFS_STATUS, 32'h00001800, "pending");
    pulse(P_SET);
    pulse(P_BND);
    `CHK(deliverNmi, 1'b1, "nmi taken")
    `CHK(deliverIntr, 1'b0, "intr waits")
    pulse(P_BND);
    `CHK(deliverIntr, 1'b1, "intr taken")
    pulse(P_BP | P_IOS);
    `CHK(deliverBpDebug, 1'b1, "bp gate set")
    `CHK(deliverIoSmi, 1'b1, "iosmi gate set")
    wb(1'b1, gegi_pkg::OFS_CTRL, 32'h00000004);
    pulse(P_CLR);
    pulse(P_XSMI | P_VINT | P_INIT);
    pulse(P_BND);
    `CHK(deliverSecurityException, 1'b0, "no sx")
    pulse(P_SET);
    pulse(P_BND);
    `CHK(deliverExtSmi, 1'b1, "xsmi")
    pulse(P_BND);
    `CHK(deliverSecurityException, 1'b1, "sx")
    `CHK(deliverInit, 1'b0, "init redirected")
    pulse(P_BND);
    `CHK(deliverVintr, 1'b1, "virtual_maskable_interrupt")
    wb(1'b1, gegi_pkg::OFS_CTRL, 32'h0);
    pulse(P_CLR);
    pulse(P_MC);
    `CHK(shutdown, 1'b1, "shutdown")
    wb(1'b1, gegi_pkg::OFS_CTRL, 32'h00000008);
    pulse(P_MC);
    `CHK(shutdown, 1'b0, "mc held")
    pulse(P_SET);
    pulse(P_BND);
    `CHK(deliverMachineCheck, 1'b1, "mc taken")
    pulse(P_HYP | P_SEC);
    `CHK(invalidOpcode, 1'b1, "ud")
    `CHK(secondaryExit, 1'b0, "no exit")
    @(posedge clock);
    hypCallIntercepted <= 1'b1;
    secondaryIntercepted <= 1'b1;
    pulse(P_HYP | P_SEC);
    `CHK(invalidOpcode, 1'b0, "intercepted")
    `CHK(secondaryExit, 1'b1, "secondary")
    pulse(P_CLR);
    @(posedge clock);
    debugRequestInput <= 1'b1;
    a20MaskPin <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    `CHK(deliverDebugReq, 1'b1, "debug_request_input")
    `CHK(a20MaskActive, 1'b1, "a20")
    wb(1'b1, gegi_pkg::OFS_CTRL, 32'h00000003);
    repeat (2) @(posedge clock);
    #1;
    `CHK(deliverDebugReq, 1'b0, "debug_request_input off")
    `CHK(a20MaskActive, 1'b0, "a20 off")
    pulse(P_NRET);
    rchk(gegi_pkg::OFS_STATUS, 32'h0, "nmi unblocked");
    wb(1'b1, gegi_pkg::OFS_DESC_LO, 32'h80000200);
    pulse(P_ENT);
    `CHK(injectValid, 1'b1, "nmi injected")
    pulse(P_SET);
    pulse(P_NMI);
    pulse(P_BND);
    `CHK(deliverNmi, 1'b1, "nmi after injection")
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    `CHK(injectType, 3'h0, "reset type")
    `CHK(injectVector, 8'h00, "reset vector")
    @(posedge clock);
    rst <= 1'b0;
    rchk(gegi_pkg::OFS_STATUS, 32'h00000001, "reset status");
    rchk(gegi_pkg::OFS_CTRL, 32'h0, "reset ctrl");
    results();
  end
endmodule
